// file: hw/drv_pkg.sv
package drv_pkg;
  // Frame geometry.
  localparam int FRAME_BITS = 24;
  localparam int COUNT_W = 5;
  localparam logic [COUNT_W-1:0] FRAME_COUNT = 5'h18;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 5'h1f;
  localparam logic [COUNT_W-1:0] COUNT_FIRST = 5'h01;
  // Control word bit positions.
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_MON_LO_BIT = 18;
  localparam int CTRL_MON_HI_BIT = 19;
  localparam int CTRL_REC_DIS_BIT = 20;
  localparam int CTRL_DUTY_BIT = 21;
  localparam int CTRL_RESET_BIT = 22;
  localparam int CTRL_ENABLE_BIT = 23;
  localparam logic CTRL_SEL_REG0 = 1'b0;
  // Status word bit positions.
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_NRDY_BIT = 18;
  localparam int STAT_WARN_BIT = 19;
  localparam int STAT_THERM_BIT = 20;
  localparam int STAT_UNDER_BIT = 21;
  localparam int STAT_OVER_BIT = 22;
  localparam int STAT_MARK_BIT = 23;
  localparam logic [23:0] STAT_RESET = 24'h00_0000;
  // Monitor multiplexer codes, bit 19 then bit 18.
  localparam logic [1:0] MON_CODE_H = 2'h0;
  localparam logic [1:0] MON_CODE_E = 2'h1;
  localparam logic [1:0] MON_CODE_A = 2'h2;
  localparam logic [1:0] MON_CODE_D = 2'h3;
  // Fault input indices.
  localparam int FIN_OVER = 0;
  localparam int FIN_UNDER = 1;
  localparam int FIN_THERM = 2;
  localparam int FIN_WARN = 3;
  localparam int FIN_COUNT = 4;
  // Timing.
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int STARTUP_TIME_US = 100;
  localparam int STARTUP_CYCLES = (STARTUP_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int TIMER_W = 13;
endpackage

// file: hw/frame_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface frame_link_if
  import drv_pkg::*;
();
  logic [FRAME_BITS-1:0] rx_word;
  logic [COUNT_W-1:0] rx_count;
  logic rx_mark;
  logic [FRAME_BITS-1:0] tx_status;
  modport frame (output rx_word, output rx_count, output rx_mark, input tx_status);
  modport core (input rx_word, input rx_count, input rx_mark, output tx_status);
endinterface
`default_nettype wire

// file: hw/serial_frame.sv
`timescale 1ns/1ps
`default_nettype none
module serial_frame
  import drv_pkg::*;
(
  // Link clock and reset.
  input wire logic sck,
  input wire logic rst_b,
  // Link pins.
  input wire logic frame_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Core side.
  frame_link_if.frame lnk
);
  logic frame_clr;
  logic started_ff;
  logic fell_ff;
  logic dout_ff;
  logic mark_ff;
  logic [COUNT_W-1:0] count_ff;
  logic [FRAME_BITS-1:0] shift_ff;
  logic [FRAME_BITS-1:0] snap_ff;

  assign frame_clr = frame_select_n | ~rst_b;

  always_ff @(posedge sck or posedge frame_clr)
  begin
    if (frame_clr)
      started_ff <= 1'b0;
    else
      started_ff <= 1'b1;
  end

  // Rising edges of one frame are counted, saturating well above a full frame.
  always_ff @(posedge sck or negedge rst_b)
  begin
    if (!rst_b)
      count_ff <= '0;
    else if (!started_ff)
      count_ff <= COUNT_FIRST;
    else if (count_ff != COUNT_MAX)
      count_ff <= count_ff + COUNT_FIRST;
  end

  // Every frame with clocks flips the mark, so a frame without clocks is seen as such.
  always_ff @(posedge sck or negedge rst_b)
  begin
    if (!rst_b)
      mark_ff <= 1'b0;
    else if (!started_ff)
      mark_ff <= ~mark_ff;
  end

  // Bit 0 arrives first and ends at the bottom after a full frame.
  always_ff @(posedge sck or negedge rst_b)
  begin
    if (!rst_b)
      shift_ff <= '0;
    else
      shift_ff <= {serial_in, shift_ff[FRAME_BITS-1:1]};
  end

  // The status word is caught at the first rising edge of the frame.
  always_ff @(posedge sck or negedge rst_b)
  begin
    if (!rst_b)
      snap_ff <= '0;
    else if (!started_ff)
      snap_ff <= lnk.tx_status;
  end

  always_ff @(negedge sck or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      fell_ff <= 1'b0;
      dout_ff <= 1'b0;
    end
    else
    begin
      fell_ff <= 1'b1;
      dout_ff <= (count_ff < FRAME_COUNT) ? snap_ff[count_ff] : 1'b0;
    end
  end

  assign serial_out = fell_ff ? dout_ff : lnk.tx_status[STAT_FAULT_BIT];
  assign serial_out_oe = ~frame_select_n;
  assign lnk.rx_word = shift_ff;
  assign lnk.rx_count = count_ff;
  assign lnk.rx_mark = mark_ff;
endmodule // serial_frame
`default_nettype wire

// file: hw/driver_control_status_upper_bits.sv
// Contract
// - Status bit 23 always reads one.
// - Enable bit: one active, zero standby cleared.
// - Bit 21 picks recovery duty 12/25.
// - Supply fault sets flag, outputs off.
// - Supply recovery automatic unless bit 20.
// - Bits 19,18 select monitored channel.
// - Thermal trip latches, outputs off until reset.
// - Heat warning reported, never disables outputs.
// - Activation starts timer; not-ready until expiry.
// - Reset bit clears status after frame.
// - Commit only frames of exactly 24 clocks.
`timescale 1ns/1ps
`default_nettype none
module driver_control_status_upper_bits
  import drv_pkg::*;
#(
  parameter int STARTUP_LEN = STARTUP_CYCLES
)
(
  // System clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Serial link.
  input wire logic sck,
  input wire logic frame_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Analogue condition inputs.
  input wire logic supply_over,
  input wire logic supply_under,
  input wire logic thermal_trip,
  input wire logic heat_warning,
  // Control outputs.
  output logic active_mode,
  output logic outputs_allowed,
  output logic recovery_duty_25,
  output logic [3:0] monitor_select
);
  frame_link_if lnk ();

  logic [1:0] sel_sync_ff;
  logic sel_prev_ff;
  logic frame_end;
  logic seen_mark_ff;
  logic [FIN_COUNT-1:0] fin_meta_ff;
  logic [FIN_COUNT-1:0] fin_ff;
  logic commit;
  logic enable_ff;
  logic duty_ff;
  logic rec_dis_ff;
  logic [1:0] mon_ff;
  logic clear_pulse;
  logic go_active;
  logic go_standby;
  logic over_ff;
  logic under_ff;
  logic therm_ff;
  logic warn_ff;
  logic nrdy_ff;
  logic [TIMER_W-1:0] timer_ff;
  logic [FRAME_BITS-1:0] status;
  logic [FRAME_BITS-1:0] hold_ff;
  logic supply_block;

  serial_frame serial_frame_i (
    .sck(sck),
    .rst_b(rst_b),
    .frame_select_n(frame_select_n),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .lnk(lnk)
  );

  // The select pin and the condition inputs pass two flip-flops.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_sync_ff <= 2'h3;
      sel_prev_ff <= 1'b1;
    end
    else
    begin
      sel_sync_ff <= {sel_sync_ff[0], frame_select_n};
      sel_prev_ff <= sel_sync_ff[1];
    end
  end

  generate
    for (genvar i = 0; i < FIN_COUNT; i++)
    begin : g_fin
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          fin_meta_ff[i] <= 1'b0;
          fin_ff[i] <= 1'b0;
        end
        else
        begin
          fin_meta_ff[i] <= (i == FIN_OVER) ? supply_over :
                            (i == FIN_UNDER) ? supply_under :
                            (i == FIN_THERM) ? thermal_trip : heat_warning;
          fin_ff[i] <= fin_meta_ff[i];
        end
      end
    end
  endgenerate

  // A frame without clocks leaves the mark alone and is never committed.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      seen_mark_ff <= 1'b0;
    else if (frame_end)
      seen_mark_ff <= lnk.rx_mark;
  end

  // Link words are stable while the select line stays high.
  assign frame_end = sel_sync_ff[1] & ~sel_prev_ff;
  assign commit = frame_end && (lnk.rx_count == FRAME_COUNT)
                  && (lnk.rx_mark != seen_mark_ff)
                  && (lnk.rx_word[CTRL_SEL_BIT] == CTRL_SEL_REG0);
  assign go_active = commit && lnk.rx_word[CTRL_ENABLE_BIT] && !enable_ff;
  assign go_standby = commit && !lnk.rx_word[CTRL_ENABLE_BIT];
  assign clear_pulse = commit && lnk.rx_word[CTRL_RESET_BIT];

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enable_ff <= 1'b0;
      duty_ff <= 1'b0;
      rec_dis_ff <= 1'b0;
      mon_ff <= MON_CODE_H;
    end
    else if (go_standby)
    begin
      enable_ff <= 1'b0;
      duty_ff <= 1'b0;
      rec_dis_ff <= 1'b0;
      mon_ff <= MON_CODE_H;
    end
    else if (commit)
    begin
      enable_ff <= 1'b1;
      duty_ff <= lnk.rx_word[CTRL_DUTY_BIT];
      rec_dis_ff <= lnk.rx_word[CTRL_REC_DIS_BIT];
      mon_ff <= lnk.rx_word[CTRL_MON_HI_BIT:CTRL_MON_LO_BIT];
    end
  end

  // Hardware sets win over a clear in the same cycle.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      over_ff <= 1'b0;
      under_ff <= 1'b0;
      therm_ff <= 1'b0;
      warn_ff <= 1'b0;
    end
    else
    begin
      over_ff <= (enable_ff && fin_ff[FIN_OVER]) ||
                 (over_ff && !clear_pulse && !go_standby);
      under_ff <= (enable_ff && fin_ff[FIN_UNDER]) ||
                  (under_ff && !clear_pulse && !go_standby);
      therm_ff <= (enable_ff && fin_ff[FIN_THERM]) ||
                  (therm_ff && !clear_pulse && !go_standby);
      warn_ff <= (enable_ff && fin_ff[FIN_WARN]) ||
                 (warn_ff && !clear_pulse && !go_standby);
    end
  end

  // Start-up timer after each standby to active change.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nrdy_ff <= 1'b0;
      timer_ff <= '0;
    end
    else if (go_active)
    begin
      nrdy_ff <= 1'b1;
      timer_ff <= TIMER_W'(STARTUP_LEN - 1);
    end
    else if (go_standby)
    begin
      nrdy_ff <= 1'b0;
      timer_ff <= '0;
    end
    else if (nrdy_ff)
    begin
      if (timer_ff == '0)
        nrdy_ff <= 1'b0;
      else
        timer_ff <= timer_ff - TIMER_W'(1);
    end
  end

  always_comb
  begin
    status = STAT_RESET;
    status[STAT_MARK_BIT] = 1'b1;
    status[STAT_OVER_BIT] = over_ff;
    status[STAT_UNDER_BIT] = under_ff;
    status[STAT_THERM_BIT] = therm_ff;
    status[STAT_WARN_BIT] = warn_ff;
    status[STAT_NRDY_BIT] = nrdy_ff;
    status[STAT_FAULT_BIT] = over_ff | under_ff | therm_ff | warn_ff;
  end

  // The read word is frozen while a frame is open.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      hold_ff <= STAT_RESET;
    else if (sel_sync_ff[1])
      hold_ff <= status;
  end

  assign lnk.tx_status = hold_ff;

  assign supply_block = fin_ff[FIN_OVER] | fin_ff[FIN_UNDER]
                        | (rec_dis_ff & (over_ff | under_ff));
  assign outputs_allowed = enable_ff && !nrdy_ff && !therm_ff
                           && !supply_block;
  assign active_mode = enable_ff;
  assign recovery_duty_25 = duty_ff;

  always_comb
  begin
    monitor_select = 4'h0;
    case (mon_ff)
      MON_CODE_A: monitor_select[0] = 1'b1;
      MON_CODE_D: monitor_select[1] = 1'b1;
      MON_CODE_E: monitor_select[2] = 1'b1;
      default: monitor_select[3] = 1'b1;
    endcase
  end
endmodule // driver_control_status_upper_bits
`default_nettype wire

// file: test/drv_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module drv_assertions (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Watched ports.
  input wire logic frame_select_n,
  input wire logic serial_out_oe,
  input wire logic supply_over,
  input wire logic supply_under,
  input wire logic thermal_trip,
  input wire logic active_mode,
  input wire logic outputs_allowed,
  input wire logic recovery_duty_25,
  input wire logic [3:0] monitor_select
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  a_over_blocks_out: assert property (supply_over [*4] |-> !outputs_allowed)
    else $error("over fault left outputs on");
  a_under_blocks_out: assert property (supply_under [*4] |-> !outputs_allowed)
    else $error("under fault left outputs on");
  a_trip_blocks_out: assert property (thermal_trip [*4] |-> !outputs_allowed)
    else $error("thermal trip left outputs on");
  a_standby_blocks: assert property (!active_mode |-> !outputs_allowed)
    else $error("outputs on in standby");
  a_standby_clears: assert property (!active_mode [*3] |->
    monitor_select == 4'h8 && !recovery_duty_25) else $error("standby kept controls");
  a_monitor_onehot: assert property ($onehot(monitor_select))
    else $error("monitor select not one-hot");
  a_start_not_ready: assert property ($rose(active_mode) |-> !outputs_allowed [*2])
    else $error("outputs on before start-up");
  a_idle_holds: assert property (frame_select_n [*8] |=>
    $stable({active_mode, recovery_duty_25, monitor_select})) else $error("controls moved");
  a_out_enable: assert property (serial_out_oe == !frame_select_n)
    else $error("data out enable does not follow select");
endmodule // drv_assertions
`default_nettype wire

// file: test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Link pins.
  output logic sck,
  output logic frame_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  logic [23:0] rd_word;
  event rd_done;
  initial
  begin
    sck = 1'b0;
    frame_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Sends a word LSB first with n clock pulses.
  task automatic xfer(input logic [23:0] w, input int n);
    #3 frame_select_n = 1'b0;
    #80;
    if (n == 0) rd_word = {24{serial_out}};
    for (int i = 0; i < n; i++)
    begin
      serial_in = w[i % 24];
      #24 sck = 1'b1;
      if (i < 24) rd_word[i] = serial_out;
      #24 sck = 1'b0;
    end
    #30 frame_select_n = 1'b1;
    serial_in = ~serial_in;
    ->rd_done;
    #110;
  endtask
endmodule // host_model
`default_nettype wire

// file: test/driver_control_status_upper_bits_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module driver_control_status_upper_bits_tb_top
  import drv_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic sck, frame_select_n, serial_in, serial_out, serial_out_oe;
  logic active_mode, outputs_allowed, recovery_duty_25;
  logic [3:0] monitor_select;
  logic [3:0] fin = 4'h0;
  logic [3:0] fl = 4'h0;
  logic [3:0] oh [4] = '{4'h8, 4'h4, 4'h1, 4'h2};
  logic act = 1'b0, dut = 1'b0, rd = 1'b0, nr = 1'b0;
  logic [1:0] mon = 2'h0;
  logic [31:0] exp_q [$];
  int fail_count = 0;
  int checks = 0;
  always #12.5 clock = ~clock;
  driver_control_status_upper_bits #(.STARTUP_LEN(8)) driver_control_status_upper_bits_i (
    .clock(clock), .rst_b(rst_b), .sck(sck), .frame_select_n(frame_select_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .supply_over(fin[FIN_OVER]), .supply_under(fin[FIN_UNDER]),
    .thermal_trip(fin[FIN_THERM]), .heat_warning(fin[FIN_WARN]),
    .active_mode(active_mode), .outputs_allowed(outputs_allowed),
    .recovery_duty_25(recovery_duty_25), .monitor_select(monitor_select));
  host_model host_model_i (.sck(sck), .frame_select_n(frame_select_n),
    .serial_in(serial_in), .serial_out(serial_out));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error frame_result expected %h seen %h", exp, seen);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] expv();
    logic ok;
    ok = act && !fl[FIN_THERM] && !(rd && (fl[FIN_OVER] || fl[FIN_UNDER]));
    return {1'b1, fl[FIN_OVER], fl[FIN_UNDER], fl[FIN_THERM], fl[FIN_WARN], nr, 17'h0,
      |fl, act, ok, dut, oh[mon], 1'b0};
  endfunction
  task automatic frm(input logic e, r, d, x, input logic [1:0] m, input int n = 24,
    input logic s = 1'b0);
    logic [31:0] ev;
    ev = expv();
    if (n == 0) ev[31:8] = {24{|fl}};
    exp_q.push_back(ev);
    nr = 1'b0;
    host_model_i.xfer({e, r, d, x, m, 17'($urandom), s}, n);
    if (n == 24 && !s)
    begin
      nr = e && !act;
      if (r || !e) fl = 4'h0;
      act = e;
      dut = e && d;
      rd = e && x;
      mon = e ? m : 2'h0;
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    #2 fin[k] = 1'b1;
    repeat (8) @(posedge clock);
    #2 fin[k] = 1'b0;
    repeat (8) @(posedge clock);
    fl[k] = fl[k] | act;
  endtask
  always @(host_model_i.rd_done)
    check({host_model_i.rd_word, active_mode, outputs_allowed, recovery_duty_25,
      monitor_select, 1'b0}, exp_q.pop_front());
  initial
  begin
    void'($urandom(89));
    repeat (16) @(posedge clock);
    #2 rst_b = 1'b1;
    repeat (4) @(posedge clock);
    frm(1, 0, 1, 0, 2'h2);
    for (int c = 0; c < 4; c++) frm(1, 0, 1'($urandom), 0, 2'(c));
    frm(0, 0, 0, 0, 2'h0, 23);
    frm(0, 0, 0, 0, 2'h0, 25);
    pulse(FIN_OVER);
    frm(1, 0, 1, 0, 2'h1);
    frm(1, 1, 1, 1, 2'h1);
    pulse(FIN_UNDER);
    frm(1, 0, 0, 1, 2'h3);
    pulse(FIN_THERM);
    pulse(FIN_WARN);
    frm(1, 1, 0, 0, 2'h3);
    pulse(FIN_WARN);
    frm(0, 0, 0, 0, 2'h0, 0);
    frm(1, 0, 0, 0, 2'h3);
    frm(0, 1, 0, 0, 2'h0, 24, 1);
    pulse(FIN_WARN);
    frm(1, 0, 0, 0, 2'h0);
    frm(0, 0, 0, 0, 2'h0);
    frm(1, 0, 0, 0, 2'h0);
    stop_test();
  end
  initial
  begin
    #100us;
    fail_count++;
    stop_test();
  end
endmodule // driver_control_status_upper_bits_tb_top
bind driver_control_status_upper_bits drv_assertions drv_assertions_i (.clock(clock),
  .rst_b(rst_b), .frame_select_n(frame_select_n), .serial_out_oe(serial_out_oe),
  .supply_over(supply_over),
  .supply_under(supply_under), .thermal_trip(thermal_trip), .active_mode(active_mode),
  .outputs_allowed(outputs_allowed), .recovery_duty_25(recovery_duty_25),
  .monitor_select(monitor_select));
`default_nettype wire
